// *** esh_health.sv ***
// package and continuous health-test module of the entropy source health control
`default_nettype none

package esh_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h04;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h08;
  localparam logic [7:0] ADDR_TEST_CTRL = 8'h0c;
  localparam logic [7:0] ADDR_RAW = 8'h10;
  localparam int OPERATIONAL_STATUS_FIELD_LSB = 30;
  localparam int WORD_BITS = 16;
  localparam int IRQ_ALARM = 0;
  localparam int IRQ_FATAL = 1;
  localparam int IRQ_WORD = 2;
  localparam int IRQ_W = 3;
  localparam logic [2:0] IRQ_MASK_RST = 3'h0;
  localparam logic TEST_EN_RST = 1'b0;
  localparam int HEALTH_WINDOW = 1024;
  localparam int STARTUP_SAMPLES = 1024;
  localparam int RCT_ALARM = 32;
  localparam int RCT_FAIL = 64;
  localparam int APT_ALARM = 640;
  localparam int APT_FAIL = 800;
  typedef enum logic [1:0] {
    esh_self_test = 2'b00,
    esh_wait = 2'b01,
    esh_valid = 2'b10,
    esh_dead = 2'b11
  } esh_state_t;
endpackage

////////////////////////////////////////////////////////////////////////////////

module esh_health #(
  parameter int WIN = esh_pkg::HEALTH_WINDOW,
  parameter int RCT_A = esh_pkg::RCT_ALARM,
  parameter int RCT_F = esh_pkg::RCT_FAIL,
  parameter int APT_A = esh_pkg::APT_ALARM,
  parameter int APT_F = esh_pkg::APT_FAIL
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic clear,
  input wire logic sample,
  input wire logic sample_valid,
  output logic alarm,
  output logic fail
);
  import esh_pkg::*;
  localparam int WW = $clog2(WIN);
  localparam int RW = $clog2(RCT_F + 1);
  localparam int AW = $clog2(WIN + 1);
  localparam logic [WW-1:0] WIN_LAST = WW'(WIN - 1);

  // counters stay internal: they may correlate with delivered bits
  logic [WW-1:0] win_q;
  logic [RW-1:0] rep_q;
  logic [AW-1:0] apt_q;
  logic last_q;
  logic ref_q;

  wire win_wrap = win_q == WIN_LAST;
  wire same = sample == last_q;
  wire rep_sat = rep_q == RW'(RCT_F);
  wire [RW-1:0] rep_d = same ? (rep_sat ? rep_q : rep_q + RW'(1)) : RW'(1);
  wire [AW-1:0] apt_d = (sample == ref_q) ? apt_q + AW'(1) : apt_q;
  wire [AW-1:0] rep_ext = AW'(rep_q);

  assign fail = sample_valid && (rep_q >= RW'(RCT_F) || apt_q >= AW'(APT_F));
  assign alarm = sample_valid && (rep_ext >= AW'(RCT_A) || apt_q >= AW'(APT_A));

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      win_q <= '0;
      rep_q <= '0;
      apt_q <= '0;
      last_q <= 1'b0;
      ref_q <= 1'b0;
    end else if (clk_en) begin
      if (clear || (sample_valid && win_wrap)) begin
        win_q <= '0;
        rep_q <= '0;
        apt_q <= '0;
        last_q <= 1'b0;
        ref_q <= 1'b0;
      end else if (sample_valid) begin
        win_q <= win_q + WW'(1);
        rep_q <= rep_d;
        last_q <= sample;
        if (win_q == '0) begin
          ref_q <= sample;
          apt_q <= AW'(1);
        end else begin
          apt_q <= apt_d;
        end
      end
    end
  end
endmodule // esh_health

`default_nettype wire

// *** esh_top.sv ***
// status, word delivery and register port of the entropy source health control
//
// Operation
// - start-up self-test runs only after reset or power-up; no software command starts it.
// - during start-up self-test every poll reports self-test state, no entropy.
// - start-up self-test failure enters fatal state, which delivers no words.
// - health or sensor error stops delivery and enters a no-output state.
// - non-critical alarm shown by returning from wait or valid to self-test.
// - critical health failure goes straight to fatal state.
// - health-test counters are never visible outside the block.
// - health-test state zeroed every window and on reset.
// - each successful poll wipes the delivered word.
// - valid status only with a complete, fully processed word.
// - raw test interface inactive while main interface operational, and reverse.
// - no word available means poll reports wait status.
// - status field encodes fatal as 11 and self-test as 00.
// - valid word carries 16 entropy bits in fixed low positions.
//
// Strobed register access and the register addresses were chosen for this implementation.
`default_nettype none

module esh_top #(
  parameter int STARTUP = esh_pkg::STARTUP_SAMPLES,
  parameter int WIN = esh_pkg::HEALTH_WINDOW
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic noise_bit,
  input wire logic noise_valid,
  input wire logic env_alarm,
  input wire logic [esh_pkg::ADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  output logic irq
);
  import esh_pkg::*;
  localparam int SW = $clog2(STARTUP + 1);
  localparam logic [SW-1:0] ST_LAST = SW'(STARTUP - 1);
  localparam int CW = $clog2(WORD_BITS + 1);
  localparam logic [CW-1:0] ACC_FULL = CW'(WORD_BITS);

  ////////////////////////////////////////////////////////////////////////////////
  // state

  esh_state_t state_q, state_d;
  logic startup_q;
  logic [SW-1:0] st_cnt_q;
  logic [WORD_BITS-1:0] acc_q;
  logic [CW-1:0] acc_cnt_q;
  logic [WORD_BITS-1:0] word_q;
  logic half_q;
  logic first_q;
  logic [WORD_BITS-1:0] raw_q;
  logic test_en_q;
  logic [IRQ_W-1:0] irq_stat_q;
  logic [IRQ_W-1:0] irq_mask_q;
  logic [31:0] rdata_q;
  logic h_alarm;
  logic h_fail;

  ////////////////////////////////////////////////////////////////////////////////
  // decode

  wire sel_status = addr == ADDR_STATUS;
  wire sel_istat = addr == ADDR_IRQ_STAT;
  wire sel_imask = addr == ADDR_IRQ_MASK;
  wire sel_test = addr == ADDR_TEST_CTRL;
  wire sel_raw = addr == ADDR_RAW;
  // a poll is a status read; its wipe relies on software using only this access
  wire poll = rd && sel_status;
  wire is_st = state_q == esh_self_test;
  wire is_live = state_q == esh_wait || state_q == esh_valid;
  wire noncrit = h_alarm || env_alarm;
  wire st_done = is_st && noise_valid && st_cnt_q == ST_LAST;
  wire st_restart = is_st && (test_en_q || noncrit);
  wire vn_emit = noise_valid && half_q && (first_q != noise_bit);
  wire acc_full = acc_cnt_q == ACC_FULL;
  wire load_word = state_q == esh_wait && acc_full && !noncrit && !test_en_q;
  // raw samples visible only while the main path is held in self-test
  wire raw_ok = test_en_q && is_st;
  // alarms keep the counts, so a stuck source still escalates to fatal
  wire hclr = test_en_q && state_q != esh_dead;

  wire ev_alarm = is_live && state_d == esh_self_test && noncrit;
  wire ev_fatal = state_q != esh_dead && state_d == esh_dead;
  wire ev_word = load_word;
  wire [IRQ_W-1:0] irq_set = {ev_word, ev_fatal, ev_alarm};
  wire [IRQ_W-1:0] irq_clr = (wr && sel_istat) ? wdata[IRQ_W-1:0] : '0;

  // data field zero in every state but valid
  wire [WORD_BITS-1:0] out_word = (state_q == esh_valid) ? word_q : '0;
  wire [31:0] status_word = {state_q, 14'h0000, out_word};
  wire [31:0] rdata_d = sel_status ? status_word :
                        sel_istat ? {29'h00000000, irq_stat_q} :
                        sel_imask ? {29'h00000000, irq_mask_q} :
                        sel_test ? {31'h00000000, test_en_q} :
                        sel_raw ? {16'h0000, raw_ok ? raw_q : 16'h0000} :
                        32'h00000000;

  assign rdata = rdata_q;
  assign irq = |(irq_stat_q & irq_mask_q);

  ////////////////////////////////////////////////////////////////////////////////
  // health tests

  esh_health #(
    .WIN(WIN)
  ) u_health (
    .clk(clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .clear(hclr),
    .sample(noise_bit),
    .sample_valid(noise_valid),
    .alarm(h_alarm),
    .fail(h_fail)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // status state machine

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      esh_dead: state_d = esh_dead;
      esh_self_test: begin
        if (h_fail) begin
          state_d = esh_dead;
        end else if (noncrit && startup_q) begin
          state_d = esh_dead;
        end else if (!st_restart && st_done) begin
          state_d = esh_wait;
        end
      end
      esh_wait: begin
        if (h_fail) begin
          state_d = esh_dead;
        end else if (noncrit || test_en_q) begin
          state_d = esh_self_test;
        end else if (acc_full) begin
          state_d = esh_valid;
        end
      end
      esh_valid: begin
        if (h_fail) begin
          state_d = esh_dead;
        end else if (noncrit || test_en_q) begin
          state_d = esh_self_test;
        end else if (poll) begin
          state_d = esh_wait;
        end
      end
    endcase
  end

  // reset is the only way into the start-up run
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= esh_self_test;
      startup_q <= 1'b1;
      st_cnt_q <= '0;
    end else if (clk_en) begin
      state_q <= state_d;
      if (st_done && !st_restart) begin
        startup_q <= 1'b0;
      end
      if (!is_st || st_restart) begin
        st_cnt_q <= '0;
      end else if (noise_valid) begin
        st_cnt_q <= st_cnt_q + SW'(1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // conditioning and word assembly

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      half_q <= 1'b0;
      first_q <= 1'b0;
      acc_q <= '0;
      acc_cnt_q <= '0;
      word_q <= '0;
      raw_q <= '0;
    end else if (clk_en) begin
      if (noise_valid) begin
        half_q <= !half_q;
        first_q <= noise_bit;
        raw_q <= raw_ok ? {raw_q[WORD_BITS-2:0], noise_bit} : '0;
      end
      // partial words are dropped whenever the source is not live
      if (!is_live || load_word) begin
        acc_q <= '0;
        acc_cnt_q <= '0;
      end else if (vn_emit && !acc_full) begin
        acc_q <= {acc_q[WORD_BITS-2:0], first_q};
        acc_cnt_q <= acc_cnt_q + CW'(1);
      end
      if (load_word) begin
        word_q <= acc_q;
      end else if (!is_live || (poll && state_q == esh_valid)) begin
        word_q <= '0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // register port and interrupt

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= '0;
      irq_stat_q <= '0;
      irq_mask_q <= IRQ_MASK_RST;
      test_en_q <= TEST_EN_RST;
    end else if (clk_en) begin
      rdata_q <= rd ? rdata_d : '0;
      // set beats a simultaneous write-one clear
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
      if (wr && sel_imask) begin
        irq_mask_q <= wdata[IRQ_W-1:0];
      end
      if (wr && sel_test) begin
        test_en_q <= wdata[0];
      end
    end
  end
endmodule // esh_top

`default_nettype wire

// *** esh_top_sva.sv ***
// assertion checker for the entropy source status port
`default_nettype none
module esh_top_chk
  import esh_pkg::*;
#(
  parameter int STARTUP = esh_pkg::STARTUP_SAMPLES
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic noise_bit,
  input wire logic noise_valid,
  input wire logic env_alarm,
  input wire logic [esh_pkg::ADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ns;
  wire logic poll_w = rd && addr == ADDR_STATUS;
  wire logic unm_w = !(addr inside {ADDR_STATUS, ADDR_IRQ_STAT, ADDR_IRQ_MASK, ADDR_TEST_CTRL,
                                    ADDR_RAW});
  // shadow copies of what the ports reveal; the inside stays hidden
  logic any_q, poll_q, raw_q, unm_q, st_q, dead_q, test_q, alm_q;
  logic [2:0] mask_q;
  int cnt_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      {any_q, poll_q, raw_q, unm_q, st_q, dead_q, test_q, alm_q} <= '0;
      mask_q <= '0;
      cnt_q <= 0;
    end else if (clk_en) begin
      any_q <= rd;
      poll_q <= poll_w;
      raw_q <= rd && addr == ADDR_RAW && !test_q;
      unm_q <= rd && unm_w;
      st_q <= poll_w && cnt_q < STARTUP && !alm_q && !env_alarm;
      if (poll_q && rdata[31:30] == 2'b11) dead_q <= 1'b1;
      if (wr && addr == ADDR_TEST_CTRL) test_q <= wdata[0];
      if (wr && addr == ADDR_IRQ_MASK) mask_q <= wdata[2:0];
      if (env_alarm) alm_q <= 1'b1;
      if (noise_valid && cnt_q < STARTUP) cnt_q <= cnt_q + 1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_idle_rdata_zero: assert property (!any_q |-> rdata == 32'h0)
    else $error("read data not zero outside a read answer");
  a_startup_self_test: assert property (st_q |-> rdata[31:30] == 2'b00)
    else $error("status left self-test before start-up samples");
  a_word_only_valid: assert property (poll_q && rdata[31:30] != 2'b10 |-> rdata[15:0] == 16'h0)
    else $error("word bits shown outside valid state");
  a_wipe_on_poll: assert property (poll_q && rdata[31:30] == 2'b10 && poll_w && clk_en
    |=> rdata[31:30] != 2'b10) else $error("same word delivered twice");
  a_fatal_sticky: assert property (dead_q && poll_q |-> rdata[31:30] == 2'b11)
    else $error("fatal state left without reset");
  a_raw_gated: assert property (raw_q |-> rdata == 32'h0)
    else $error("raw samples visible with test off");
  a_unmapped_zero: assert property (unm_q |-> rdata == 32'h0)
    else $error("unmapped read not zero");
  a_irq_needs_mask: assert property (irq |-> mask_q != 3'h0)
    else $error("interrupt with all causes masked");
  c_valid_poll: cover property (poll_q && rdata[31:30] == 2'b10);
  c_dead_poll: cover property (poll_q && rdata[31:30] == 2'b11);
  c_irq_up: cover property (irq);
endmodule // esh_top_chk
bind esh_top esh_top_chk #(.STARTUP(STARTUP)) chk_u (.clk(clk), .rst_b(rst_b), .clk_en(clk_en),
  .noise_bit(noise_bit), .noise_valid(noise_valid), .env_alarm(env_alarm), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq));
`default_nettype wire

// *** esh_top_tb.sv ***
// self-checking testbench for the entropy source status port
`default_nettype none
module esh_top_tb
  import esh_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int ST = 16;
  localparam logic [31:0] M = 32'hc000_ffff;
  localparam logic [31:0] WAITS = 32'h4000_0000;
  localparam logic [31:0] DEADS = 32'hc000_0000;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic clk_en = 1'b1;
  logic noise_bit = 1'b0;
  logic noise_valid = 1'b0;
  logic env_alarm = 1'b0;
  logic [7:0] addr = 8'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic irq;
  int bad_count = 0;
  int n_checks = 0;
  always #25 clk = ~clk;
  // long window so a 64-sample repetition run fits inside one
  esh_top #(.STARTUP(ST), .WIN(128)) dut_u (.clk(clk), .rst_b(rst_b), .clk_en(clk_en),
    .noise_bit(noise_bit), .noise_valid(noise_valid), .env_alarm(env_alarm), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata & m, e);
  endtask
  // two polls with no gap, so a wipe has no spare cycle to hide in
  task automatic poll_pair(input logic [31:0] e1, input logic [31:0] e2);
    @(posedge clk);
    addr <= ADDR_STATUS;
    rd <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    chk(rdata & M, e1);
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata & M, e2);
  endtask
  task automatic feed(input int n, input logic first, input logic alt);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      noise_valid <= 1'b1;
      noise_bit <= first ^ (alt & i[0]);
      @(posedge clk);
      noise_valid <= 1'b0;
    end
  endtask
  task automatic pulse_alarm();
    @(posedge clk);
    env_alarm <= 1'b1;
    @(posedge clk);
    env_alarm <= 1'b0;
  endtask
  task automatic do_reset();
    rst_b <= 1'b0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    finish_test();
  end
  initial begin
    do_reset();
    rd_chk(ADDR_STATUS, 32'h0, M);
    rd_chk(ADDR_IRQ_MASK, 32'h0, '1);
    rd_chk(ADDR_TEST_CTRL, 32'h0, '1);
    wr_reg(8'h20, '1);
    rd_chk(8'h20, 32'h0, '1);
    feed(ST, 1'b1, 1'b1);
    rd_chk(ADDR_STATUS, WAITS, M);
    feed(32, 1'b1, 1'b1);
    poll_pair(32'h8000_ffff, WAITS);
    rd_chk(ADDR_IRQ_STAT, 32'h4, 32'h7);
    wr_reg(ADDR_IRQ_MASK, 32'h4);
    @(negedge clk);
    chk({31'h0, irq}, 32'h1);
    wr_reg(ADDR_IRQ_STAT, 32'h4);
    @(negedge clk);
    chk({31'h0, irq}, 32'h0);
    $display("test words done");
    wr_reg(ADDR_TEST_CTRL, 32'h1);
    rd_chk(ADDR_STATUS, 32'h0, M);
    feed(ST, 1'b1, 1'b1);
    rd_chk(ADDR_RAW, 32'haaaa, '1);
    wr_reg(ADDR_TEST_CTRL, 32'h0);
    rd_chk(ADDR_RAW, 32'h0, '1);
    feed(ST, 1'b1, 1'b1);
    rd_chk(ADDR_STATUS, WAITS, M);
    $display("test raw done");
    wr_reg(ADDR_IRQ_STAT, 32'h7);
    pulse_alarm();
    rd_chk(ADDR_STATUS, 32'h0, M);
    rd_chk(ADDR_IRQ_STAT, 32'h1, 32'h3);
    feed(200, 1'b1, 1'b0);
    rd_chk(ADDR_STATUS, DEADS, M);
    rd_chk(ADDR_IRQ_STAT, 32'h2, 32'h2);
    wr_reg(ADDR_IRQ_STAT, 32'h7);
    wr_reg(ADDR_STATUS, 32'h0);
    wr_reg(ADDR_TEST_CTRL, 32'h1);
    wr_reg(ADDR_TEST_CTRL, 32'h0);
    feed(48, 1'b1, 1'b1);
    rd_chk(ADDR_STATUS, DEADS, M);
    $display("test alarms done");
    do_reset();
    rd_chk(ADDR_STATUS, 32'h0, M);
    rd_chk(ADDR_IRQ_STAT, 32'h0, '1);
    pulse_alarm();
    feed(ST, 1'b1, 1'b1);
    rd_chk(ADDR_STATUS, DEADS, M);
    $display("test startup fail done");
    finish_test();
  end
endmodule // esh_top_tb
`default_nettype wire
